// ### e1_yellow_alarm_irq.sv
// Receive E1 yellow alarm detection with change flags, enables and interrupt
`timescale 1ns/1ps
module e1_yellow_alarm_irq (
    input wire logic clk_i,
    input wire logic rst_i,
    input wire logic cyc_i,
    input wire logic stb_i,
    input wire logic we_i,
    input wire logic [yel_irq_pkg::WB_ADR_W-1:0] adr_i,
    input wire logic [yel_irq_pkg::WB_SEL_W-1:0] sel_i,
    input wire logic [yel_irq_pkg::WB_DAT_W-1:0] dat_i,
    output logic [yel_irq_pkg::WB_DAT_W-1:0] dat_o,
    output logic ack_o,
    input wire logic nonfas_valid_i,
    input wire logic a_bit_i,
    input wire logic mf0_valid_i,
    input wire logic y_bit_i,
    output logic irq_o
);
    import yel_irq_pkg::*;

    alarm_if alarms ();

    alarm_detect u_detect (
        .clk_i(clk_i),
        .rst_i(rst_i),
        .nonfas_valid_i(nonfas_valid_i),
        .a_bit_i(a_bit_i),
        .mf0_valid_i(mf0_valid_i),
        .y_bit_i(y_bit_i),
        .bus(alarms.det)
    );

    logic next_ack;
    logic [WB_DAT_W-1:0] next_dat;
    logic [DATA_W-1:0] status, next_status;
    logic [DATA_W-1:0] enable, next_enable;
    logic [DATA_W-1:0] enable_view;
    logic next_irq;
    logic req, start, commit, hit_status, hit_enable;
    logic enable_wr;

    // Request decode; a request is answered one cycle after it appears
    assign req = cyc_i & stb_i;
    assign start = req & ~ack_o;
    assign commit = req & ack_o;
    assign hit_status = (adr_i == STATUS_ADDR);
    assign hit_enable = (adr_i == ENABLE_ADDR);
    assign enable_wr = commit & hit_enable & we_i & sel_i[0];

    always_comb begin
        enable_view = enable & ENABLE_RW_MASK;
        enable_view[YEL_STATE_BIT] = alarms.yellow_active;
    end

    // Bus answer: ack for one cycle, read data captured with it
    always_comb begin
        next_ack = start;
        next_dat = dat_o;
        if (start) begin
            next_dat = '0;
            if (hit_status) begin
                next_dat[DATA_W-1:0] = status & STATUS_MASK;
            end else if (hit_enable) begin
                next_dat[DATA_W-1:0] = enable_view;
            end
        end
    end

    // Status flags. Only the bits shown to the reader are cleared, so an
    // event that lands between the snapshot and the commit edge survives.
    always_comb begin
        next_status = status;
        if (commit && hit_status && !we_i) begin
            next_status = status & ~dat_o[DATA_W-1:0];
        end
        if (alarms.yellow_change) begin
            next_status[YEL_CHG_BIT] = 1'b1;
        end
        if (alarms.cas_change) begin
            next_status[CAS_CHG_BIT] = 1'b1;
        end
    end

    // Enables; unimplemented bits stay zero
    always_comb begin
        next_enable = enable;
        if (enable_wr) begin
            next_enable = dat_i[DATA_W-1:0] & ENABLE_RW_MASK;
        end
    end

    // Interrupt from the next values so it tracks flags without extra lag
    always_comb begin
        next_irq = |(next_status & next_enable & STATUS_MASK);
    end

    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            ack_o <= 1'b0;
            dat_o <= RDATA_RESET;
            status <= STATUS_RESET;
            enable <= ENABLE_RESET;
            irq_o <= 1'b0;
        end else begin
            ack_o <= next_ack;
            dat_o <= next_dat;
            status <= next_status;
            enable <= next_enable;
            irq_o <= next_irq;
        end
    end

    // A sample history kept for the checks only; the filter has its own count
    logic [1:0] a_hist, next_a_hist;

    always_comb begin
        next_a_hist = a_hist;
        if (nonfas_valid_i) begin
            next_a_hist = {a_hist[0], a_bit_i};
        end
    end

    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            a_hist <= 2'b00;
        end else begin
            a_hist <= next_a_hist;
        end
    end

    default clocking cb @(posedge clk_i);
    endclocking
    default disable iff (rst_i);

    sequence status_read_commit;
        commit && hit_status && !we_i;
    endsequence

    sequence enable_write_commit;
        enable_wr;
    endsequence

    sequence a_one_twice;
        nonfas_valid_i && a_bit_i && a_hist[0];
    endsequence

    sequence a_zero_twice;
        nonfas_valid_i && !a_bit_i && !a_hist[0];
    endsequence

    a_ack_follows_req: assert property (
        start |=> ack_o ##1 !ack_o
    ) else $error("ack not a single cycle after request");

    a_yel_flag_set: assert property (
        alarms.yellow_change |=> status[YEL_CHG_BIT]
    ) else $error("yellow change did not set status bit 0");

    a_yel_read_clear: assert property (
        status_read_commit ##0 dat_o[YEL_CHG_BIT]
        ##0 !alarms.yellow_change |=> !status[YEL_CHG_BIT]
    ) else $error("status read did not clear yellow flag");

    a_yel_irq_raise: assert property (
        alarms.yellow_change && enable[YEL_EN_BIT]
        && !enable_wr |=> irq_o
    ) else $error("enabled yellow change gave no interrupt");

    a_yel_declare: assert property (
        alarms.yellow_change && alarms.yellow_active
        |-> a_hist == 2'b11
    ) else $error("yellow declared without two A bits one");

    a_yel_clear: assert property (
        alarms.yellow_change && !alarms.yellow_active
        |-> a_hist == 2'b00
    ) else $error("yellow cleared without two A bits zero");

    a_yel_two_ones: assert property (
        a_one_twice ##0 !alarms.yellow_active
        |=> alarms.yellow_change && alarms.yellow_active
    ) else $error("two A bits one did not declare yellow");

    a_yel_two_zeros: assert property (
        a_zero_twice ##0 alarms.yellow_active
        |=> alarms.yellow_change && !alarms.yellow_active
    ) else $error("two A bits zero did not clear yellow");

    a_yel_edge: assert property (
        $changed(alarms.yellow_active) |-> alarms.yellow_change
    ) else $error("yellow state changed without change pulse");

    a_state_bit: assert property (
        start && hit_enable
        |=> dat_o[YEL_STATE_BIT] == $past(alarms.yellow_active)
    ) else $error("enable bit 7 does not show yellow state");

    a_cas_en_write: assert property (
        enable_write_commit |=> enable[CAS_EN_BIT] == $past(dat_i[CAS_EN_BIT])
    ) else $error("multiframe enable bit not written");

    a_cas_irq_raise: assert property (
        alarms.cas_change && enable[CAS_EN_BIT]
        && !enable_wr |=> irq_o
    ) else $error("enabled multiframe change gave no interrupt");

    a_cas_flag_set: assert property (
        alarms.cas_change |=> status[CAS_CHG_BIT]
    ) else $error("multiframe change did not set status bit 5");

    a_cas_follow_y: assert property (
        mf0_valid_i |=> alarms.cas_active == $past(y_bit_i)
    ) else $error("multiframe yellow does not follow y bit");

    a_yel_en_gate: assert property (
        !enable[YEL_EN_BIT] && !(status[CAS_CHG_BIT] && enable[CAS_EN_BIT])
        && !enable_wr ##1 !enable[YEL_EN_BIT]
        && !(status[CAS_CHG_BIT] && enable[CAS_EN_BIT]) |-> !irq_o
    ) else $error("interrupt with yellow enable off");

    a_cas_read_clear: assert property (
        status_read_commit ##0 dat_o[CAS_CHG_BIT]
        ##0 !alarms.cas_change |=> !status[CAS_CHG_BIT]
    ) else $error("status read did not clear multiframe flag");

    a_irq_level: assert property (
        irq_o == |(status & enable & STATUS_MASK)
    ) else $error("interrupt not matching enabled flags");

    a_enable_hold: assert property (
        !enable_wr |=> enable == $past(enable)
    ) else $error("enable changed without a write");

    // Status is read-clear only, so a write must leave it alone
    a_status_no_write: assert property (
        commit && hit_status && we_i && !alarms.yellow_change
        && !alarms.cas_change |=> status == $past(status)
    ) else $error("status write changed a flag");

    a_ack_needs_req: assert property (
        ack_o |-> $past(start)
    ) else $error("ack without a request");

    a_dat_upper_zero: assert property (
        ack_o |-> dat_o[WB_DAT_W-1:DATA_W] == '0
    ) else $error("read data upper bits not zero");

    a_rsvd_zero: assert property (
        (enable & ~ENABLE_RW_MASK) == '0 && (status & ~STATUS_MASK) == '0
    ) else $error("unimplemented register bit set");
endmodule // e1_yellow_alarm_irq

// ### yel_irq_pkg.sv
// Constants shared by the receive yellow alarm interrupt block
package yel_irq_pkg;
    localparam int DATA_W = 8;
    localparam int WB_ADR_W = 8;
    localparam int WB_DAT_W = 32;
    localparam int WB_SEL_W = 4;

    // Register indices; the byte address is four times the index
    localparam logic [WB_ADR_W-1:0] STATUS_IDX = 8'h02;
    localparam logic [WB_ADR_W-1:0] ENABLE_IDX = 8'h03;
    localparam logic [WB_ADR_W-1:0] STATUS_ADDR = {STATUS_IDX[5:0], 2'b00};
    localparam logic [WB_ADR_W-1:0] ENABLE_ADDR = {ENABLE_IDX[5:0], 2'b00};

    // Field positions
    localparam int YEL_CHG_BIT = 0;
    localparam int CAS_CHG_BIT = 5;
    localparam int YEL_EN_BIT = 0;
    localparam int CAS_EN_BIT = 5;
    localparam int YEL_STATE_BIT = 7;

    // Implemented bits and values after reset
    localparam logic [DATA_W-1:0] STATUS_MASK = 8'h21;
    localparam logic [DATA_W-1:0] ENABLE_RW_MASK = 8'h21;
    localparam logic [DATA_W-1:0] STATUS_RESET = 8'h00;
    localparam logic [DATA_W-1:0] ENABLE_RESET = 8'h00;
    localparam logic [WB_DAT_W-1:0] RDATA_RESET = 32'h0000_0000;

    // Consecutive samples needed to change each alarm state
    localparam int YEL_CONSEC = 2;
    localparam int CAS_CONSEC = 1;

    // Nominal yellow declare/clear time in clock cycles
    localparam int CLK_PERIOD_NS = 100;
    localparam int YEL_DELAY_US = 375;
    localparam int YEL_DELAY_CYCLES = (YEL_DELAY_US * 1000) / CLK_PERIOD_NS;
endpackage // yel_irq_pkg

// ### alarm_if.sv
// Alarm states and change pulses from the detector to the register block
`timescale 1ns/1ps
interface alarm_if;
    logic yellow_active;
    logic yellow_change;
    logic cas_active;
    logic cas_change;

    modport det (
        output yellow_active,
        output yellow_change,
        output cas_active,
        output cas_change
    );
    modport ctl (
        input yellow_active,
        input yellow_change,
        input cas_active,
        input cas_change
    );
endinterface // alarm_if

// ### consec_filter.sv
// Alarm state that flips after N consecutive contrary samples
`timescale 1ns/1ps
module consec_filter #(
    parameter int N = 2
) (
    input wire logic clk_i,
    input wire logic rst_i,
    input wire logic sample_i,
    input wire logic bit_i,
    output logic state_o,
    output logic change_o
);
    localparam int CNT_W = $clog2(N + 1);
    localparam logic [CNT_W-1:0] LAST = CNT_W'(N - 1);

    // Refuse a filter that could never change state
    if (N < 1) begin : g_bad_n
        $error("consec_filter needs N of at least 1");
    end

    logic [CNT_W-1:0] cnt, next_cnt;
    logic next_state, next_change;

    always_comb begin
        next_cnt = cnt;
        next_state = state_o;
        next_change = 1'b0;
        if (sample_i) begin
            if (bit_i == state_o) begin
                next_cnt = '0;
            end else if (cnt == LAST) begin
                next_state = ~state_o;
                next_change = 1'b1;
                next_cnt = '0;
            end else begin
                next_cnt = cnt + CNT_W'(1);
            end
        end
    end

    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            cnt <= '0;
            state_o <= 1'b0;
            change_o <= 1'b0;
        end else begin
            cnt <= next_cnt;
            state_o <= next_state;
            change_o <= next_change;
        end
    end
endmodule // consec_filter

// ### alarm_detect.sv
// Yellow and CAS multiframe yellow detectors feeding the alarm interface
`timescale 1ns/1ps
module alarm_detect (
    input wire logic clk_i,
    input wire logic rst_i,
    input wire logic nonfas_valid_i,
    input wire logic a_bit_i,
    input wire logic mf0_valid_i,
    input wire logic y_bit_i,
    alarm_if.det bus
);
    import yel_irq_pkg::*;

    // Remote alarm from the A bit of non-FAS frames
    consec_filter #(.N(YEL_CONSEC)) u_yellow (
        .clk_i(clk_i),
        .rst_i(rst_i),
        .sample_i(nonfas_valid_i),
        .bit_i(a_bit_i),
        .state_o(bus.yellow_active),
        .change_o(bus.yellow_change)
    );

    // Multiframe yellow follows every y bit of TS16 in frame 0
    consec_filter #(.N(CAS_CONSEC)) u_cas (
        .clk_i(clk_i),
        .rst_i(rst_i),
        .sample_i(mf0_valid_i),
        .bit_i(y_bit_i),
        .state_o(bus.cas_active),
        .change_o(bus.cas_change)
    );
endmodule // alarm_detect

// ### framer_model.sv
// Receive framer overhead bit source for the yellow alarm block
`timescale 1ns/1ps
module framer_model (
    input wire logic clk_i,
    output logic nonfas_valid_o,
    output logic a_bit_o,
    output logic mf0_valid_o,
    output logic y_bit_o
);
    initial begin
        {nonfas_valid_o, a_bit_o, mf0_valid_o, y_bit_o} = 4'h0;
    end

    // One sample pulse; data lines invert after it so stale bits never pass
    task automatic send(input logic cas, input logic b);
        @(posedge clk_i);
        if (cas) begin
            {mf0_valid_o, y_bit_o} <= {1'b1, b};
        end else begin
            {nonfas_valid_o, a_bit_o} <= {1'b1, b};
        end
        @(posedge clk_i);
        {nonfas_valid_o, mf0_valid_o} <= 2'h0;
        {a_bit_o, y_bit_o} <= {~a_bit_o, ~y_bit_o};
    endtask
endmodule // framer_model

// ### e1_yellow_alarm_irq_bench.sv
// Self-checking bench for the yellow alarm interrupt block
`timescale 1ns/1ps
module e1_yellow_alarm_irq_bench;
    import yel_irq_pkg::*;
    logic clk_i = 1'b0;
    logic rst_i = 1'b1;
    logic cyc = 1'b0, stb = 1'b0, we = 1'b0;
    logic [WB_ADR_W-1:0] adr = 8'h00;
    logic [WB_SEL_W-1:0] sel = 4'h0;
    logic [WB_DAT_W-1:0] dat = 32'h0, dat_o, q;
    logic ack_o, irq_o, nv, ab, mv, yb;
    logic [31:0] r;
    int error_cnt = 0, n_tests = 0;
    // Reference state: alarms, filter count, flags, enables
    int yel = 0, cnt = 0, cas = 0, flags = 0, en = 0;

    always #50 clk_i = ~clk_i;

    framer_model fm (.clk_i(clk_i), .nonfas_valid_o(nv), .a_bit_o(ab),
        .mf0_valid_o(mv), .y_bit_o(yb));

    e1_yellow_alarm_irq DUT (.clk_i(clk_i), .rst_i(rst_i), .cyc_i(cyc),
        .stb_i(stb), .we_i(we), .adr_i(adr), .sel_i(sel), .dat_i(dat),
        .dat_o(dat_o), .ack_o(ack_o), .nonfas_valid_i(nv), .a_bit_i(ab),
        .mf0_valid_i(mv), .y_bit_i(yb), .irq_o(irq_o));

    task automatic chk_reg(input logic [31:0] got, input logic [31:0] exp);
        n_tests++;
        if (got !== exp) begin
            error_cnt++;
            $display("ERROR %0t got %h exp %h", $time, got, exp);
        end
    endtask

    task automatic chk_irq(input logic got, input logic exp);
        n_tests++;
        if (got !== exp) begin
            error_cnt++;
            $display("ERROR %0t irq got %h exp %h", $time, got, exp);
        end
    endtask

    // Classic cycle: hold until ack is sampled, then release
    task automatic wb(input logic w, input logic [7:0] a,
        input logic [31:0] d, input logic [3:0] s, output logic [31:0] rd);
        @(posedge clk_i);
        {cyc, stb, we, adr, dat, sel} <= {2'b11, w, a, d, s};
        // Only the watchdog ends a wait for ack
        do begin
            @(posedge clk_i);
        end while (ack_o !== 1'b1);
        rd = dat_o;
        {cyc, stb, we} <= 3'h0;
    endtask

    // irq_o moves at the clearing edge, so look after it settles
    task automatic chk_line;
        @(negedge clk_i);
        chk_irq(irq_o, (flags & en) != 0);
    endtask

    task automatic rd_status;
        wb(1'b0, STATUS_ADDR, 32'h0, 4'hF, q);
        chk_reg(q, 32'(flags));
        flags = 0;
        chk_line;
    endtask

    task automatic rd_enable;
        wb(1'b0, ENABLE_ADDR, 32'h0, 4'hF, q);
        chk_reg(q, 32'(en | (yel << 7)));
    endtask

    task automatic wr_enable(input logic [7:0] d, input logic [3:0] s);
        wb(1'b1, ENABLE_ADDR, {24'h0, d}, s, q);
        if (s[0]) en = d & 8'h21;
        chk_line;
    endtask

    task automatic smp(input logic c, input logic b);
        fm.send(c, b);
        if (c) begin
            if (b != cas) begin
                cas = b;
                flags |= 32'h20;
            end
        end else if (b == yel) begin
            cnt = 0;
        end else if (++cnt == 2) begin
            yel = b;
            cnt = 0;
            flags |= 32'h1;
        end
        repeat (3) @(posedge clk_i);
        chk_line;
    endtask

    task automatic test_done;
        if (error_cnt == 0 && n_tests > 0) begin
            $display("STATUS OK");
        end else begin
            $display("STATUS NOT OK");
        end
        $finish;
    endtask

    initial begin
        #(100 * 30000);
        error_cnt++;
        test_done;
    end

    initial begin
        void'($urandom(32'hFE472E7A));
        repeat (10) @(posedge clk_i);
        rst_i <= 1'b0;
        rd_status;
        rd_enable;
        // Status writes and writes without lane 0 must not stick
        wb(1'b1, STATUS_ADDR, 32'hFF, 4'hF, q);
        wr_enable(8'hFF, 4'hE);
        rd_status;
        rd_enable;
        wr_enable(8'hFF, 4'h1);
        rd_enable;
        // A lone contrary A bit must not count toward a change
        for (int i = 0; i < 8; i++) begin
            smp(1'b0, 1'(8'h2D >> i));
            rd_enable;
        end
        rd_status;
        for (int i = 0; i < 120; i++) begin
            r = $urandom;
            case (r[2:0])
                3'h4: rd_status;
                3'h5: rd_enable;
                3'h6: wr_enable(r[15:8], r[19:16]);
                3'h7: begin
                    wb(r[6], r[5] ? 8'h40 : 8'h04, r, 4'hF, q);
                    if (!r[6]) chk_reg(q, 32'h0);
                end
                default: smp(r[3], r[4]);
            endcase
        end
        rd_enable;
        rd_status;
        // Mid-run reset drops every flag, enable and alarm state
        @(posedge clk_i);
        rst_i <= 1'b1;
        repeat (3) @(posedge clk_i);
        chk_irq(irq_o, 1'b0);
        rst_i <= 1'b0;
        yel = 0;
        cnt = 0;
        cas = 0;
        flags = 0;
        en = 0;
        rd_enable;
        rd_status;
        test_done;
    end
endmodule // e1_yellow_alarm_irq_bench
